/* File: hdl/psq_pkg.sv */
// package: constants and types shared by the program sequencer and its return stack
package psq_pkg;
  // ==========================================================
  // memory geometry
  localparam int IP_W_DEF = 11;
  localparam int PG_OFF_W = 7;
  localparam int WORD_W = 9;
  localparam int TOP_BIT = 8;
  localparam int TBL_D_W = 3;
  localparam int ACC_W = 4;
  localparam int FILE_W_DEF = 2;
  localparam int DIGIT_W = 4;
  localparam int PAGE_SUB = 2;
  // ==========================================================
  // return stack
  localparam int STK_DEPTH = 4;
  localparam int LVL_W = 2;
  localparam logic [1:0] LVL_RST = 2'h3;
  // ==========================================================
  // machine cycle divider
  localparam int TICK_DIV = 4;
  localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
  // ==========================================================
  // apb register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IP = 8'h08;
  localparam logic [7:0] OFF_DPTR = 8'h0c;
  localparam int CTRL_REINIT = 0;
  localparam int CTRL_HALT = 1;
  localparam int STAT_FLAG = 0;
  localparam int STAT_CARRY = 1;
  localparam int STAT_LVL = 2;
  localparam int STAT_ST = 4;
  localparam int STAT_SKIP = 6;
  localparam int DPTR_FILE = 4;
  // ==========================================================
  // operations and states
  typedef enum logic [3:0] {
    OP_SEQ = 4'h0, OP_JUMP = 4'h1, OP_CALL = 4'h2, OP_P2CALL = 4'h3,
    OP_RET = 4'h4, OP_RETS = 4'h5, OP_TABLE = 4'h6, OP_TOPBIT = 4'h7,
    OP_SETX = 4'h8, OP_SETY = 4'h9, OP_PSET = 4'ha, OP_PCLR = 4'hb,
    OP_PTEST = 4'hc, OP_MSET = 4'hd, OP_MCLR = 4'he, OP_MTEST = 4'hf
  } psq_op_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0, ST_TBL = 2'h1, ST_RET = 2'h2
  } psq_st_e;
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_SET = 2'h1;
  localparam logic [1:0] KIND_CLR = 2'h2;
  localparam logic [1:0] KIND_TEST = 2'h3;
endpackage : psq_pkg

/* File: hdl/psq_stack_if.sv */
// interface: sequencer to return stack
`timescale 1ns/1ps
`default_nettype none
interface psq_stack_if #(parameter int IP_W = 11);
  logic init;
  logic push;
  logic pop;
  logic [IP_W-1:0] wdata;
  logic [IP_W-1:0] top;
  logic [1:0] level;
  modport seq (output init, push, pop, wdata, input top, level);
  modport stk (input init, push, pop, wdata, output top, level);
endinterface : psq_stack_if
`default_nettype wire

/* File: hdl/psq_stack.sv */
// module: four-entry return stack with wrapping level pointer
`timescale 1ns/1ps
`default_nettype none
module psq_stack
  import psq_pkg::*;
#(
  parameter int IP_W = IP_W_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  psq_stack_if.stk stk
);
  typedef struct packed {
    logic [LVL_W-1:0] lvl;
    logic [STK_DEPTH-1:0][IP_W-1:0] slot;
  } psq_stk_s;
  psq_stk_s s_ff, nxt_s;

  // ==========================================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    if (stk.init) begin
      nxt_s.lvl = LVL_RST;
    end else if (stk.push) begin
      nxt_s.lvl = s_ff.lvl + 2'h1;
      nxt_s.slot[nxt_s.lvl] = stk.wdata;
    end else if (stk.pop) begin
      nxt_s.lvl = s_ff.lvl - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{lvl: LVL_RST, slot: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign stk.top = s_ff.slot[s_ff.lvl];
  assign stk.level = s_ff.lvl;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ptr_wrap_full: assert property (stk.push && !stk.init && s_ff.lvl == 2'h3 |=> s_ff.lvl == 2'h0)
    else $error("pointer did not wrap to zero");
  a_push_store_top: assert property (stk.push && !stk.init |=> stk.top == $past(stk.wdata))
    else $error("pushed address not on top");
  a_pop_step_back: assert property (stk.pop && !stk.push && !stk.init |=> s_ff.lvl == $past(s_ff.lvl) - 2'h1)
    else $error("pop did not step pointer back");
  c_full_wrap: cover property (stk.push && s_ff.lvl == 2'h3 && !stk.init);
endmodule : psq_stack
`default_nettype wire

/* File: hdl/psq_seq.sv */
// module: program sequencer core with apb status and control
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module psq_seq
  import psq_pkg::*;
#(
  parameter int IP_W = IP_W_DEF,
  parameter int FILE_W = FILE_W_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_pin,
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [1:0] op_len,
  input wire logic [IP_W-1:0] op_target,
  input wire logic op_cond,
  input wire logic [ACC_W-1:0] acc,
  input wire logic [TBL_D_W-1:0] tbl_dreg,
  input wire logic [WORD_W-1:0] rom_data,
  input wire logic carry_wr,
  input wire logic carry_wd,
  output logic op_ready,
  output logic machine_tick,
  output logic [IP_W-1:0] instruction_pointer,
  output logic [IP_W-1:0] tbl_addr,
  output logic tbl_rd,
  output logic [7:0] tbl_word,
  output logic tbl_vld,
  output logic carry_flag,
  output logic top_bit_enable_flag,
  output logic [FILE_W-1:0] ram_file,
  output logic [DIGIT_W-1:0] ram_digit,
  output logic [1:0] ram_bit_sel,
  output logic [1:0] ram_bit_kind,
  output logic ram_bit_stb,
  output logic [1:0] port_bit_kind,
  output logic port_bit_stb,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int PG_W = IP_W - PG_OFF_W;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [1:0] cnt;
    logic tick;
    psq_st_e st;
    logic ready;
    logic halt;
    logic [IP_W-1:0] ip;
    logic skip;
    logic flag;
    logic carry;
    logic [FILE_W-1:0] file;
    logic [DIGIT_W-1:0] digit;
    logic [IP_W-1:0] taddr;
    logic trd;
    logic [7:0] tword;
    logic tvld;
    logic [1:0] bsel;
    logic [1:0] bkind;
    logic bstb;
    logic [1:0] pkind;
    logic pstb;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } psq_seq_s;

  psq_seq_s s_ff, nxt_s;
  psq_stack_if #(.IP_W(IP_W)) stk_if ();

  logic tick;
  logic init;
  logic take;
  logic hit;
  logic wr;
  psq_op_e op;
  logic [IP_W-1:0] ip_next;

  // ==========================================================
  // decode helpers
  // tick every fourth clock
  assign tick = (s_ff.cnt == TICK_LAST);
  assign op = psq_op_e'(op_code);
  assign wr = psel && penable && pwrite && s_ff.rdy && !s_ff.err;
  assign init = s_ff.sync2 || (wr && paddr == OFF_CTRL && pwdata[CTRL_REINIT]);
  assign take = tick && op_valid && s_ff.ready && !init;
  assign ip_next = s_ff.ip + IP_W'(op_len);
  assign hit = (paddr == OFF_CTRL) || (paddr == OFF_STAT) ||
               (paddr == OFF_IP) || (paddr == OFF_DPTR);

  psq_stack #(.IP_W(IP_W)) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .stk(stk_if.stk)
  );

  // ==========================================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    stk_if.init = 1'b0;
    stk_if.push = 1'b0;
    stk_if.pop = 1'b0;
    stk_if.wdata = ip_next;
    nxt_s.sync1 = wake_pin;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.cnt = s_ff.cnt + 2'h1;
    nxt_s.tick = (nxt_s.cnt == TICK_LAST);
    nxt_s.trd = 1'b0;
    nxt_s.tvld = 1'b0;
    nxt_s.bstb = 1'b0;
    nxt_s.pstb = 1'b0;
    if (carry_wr) begin
      nxt_s.carry = carry_wd;
    end
    if (init) begin
      nxt_s.flag = 1'b0;
      stk_if.init = 1'b1;
      nxt_s.st = ST_RUN;
      nxt_s.skip = 1'b0;
    end else if (take && s_ff.skip) begin
      nxt_s.skip = 1'b0;
      nxt_s.ip = ip_next;
    end else if (take) begin
      nxt_s.ip = ip_next;
      case (op)
        OP_SEQ: begin
          nxt_s.skip = op_cond;
        end
        OP_JUMP: begin
          nxt_s.ip = op_target;
        end
        OP_CALL: begin
          stk_if.push = 1'b1;
          nxt_s.ip = op_target;
        end
        OP_P2CALL: begin
          stk_if.push = 1'b1;
          nxt_s.ip = {PG_W'(PAGE_SUB), op_target[PG_OFF_W-1:0]};
        end
        OP_RET, OP_RETS: begin
          stk_if.pop = 1'b1;
          nxt_s.ip = stk_if.top;
          nxt_s.skip = (op == OP_RETS);
          nxt_s.st = ST_RET;
        end
        OP_TABLE: begin
          stk_if.push = 1'b1;
          nxt_s.taddr = {op_target[IP_W-1:PG_OFF_W], tbl_dreg, acc};
          nxt_s.trd = 1'b1;
          nxt_s.st = ST_TBL;
        end
        OP_TOPBIT: begin
          nxt_s.flag = 1'b1;
        end
        OP_SETX: begin
          nxt_s.file = op_target[FILE_W-1:0];
        end
        OP_SETY: begin
          nxt_s.digit = op_target[DIGIT_W-1:0];
        end
        OP_PSET, OP_PCLR, OP_PTEST: begin
          nxt_s.pstb = 1'b1;
          nxt_s.pkind = (op == OP_PSET) ? KIND_SET :
                        (op == OP_PCLR) ? KIND_CLR : KIND_TEST;
          nxt_s.skip = (op == OP_PTEST) && op_cond;
        end
        OP_MSET, OP_MCLR, OP_MTEST: begin
          nxt_s.bstb = 1'b1;
          nxt_s.bsel = op_target[1:0];
          nxt_s.bkind = (op == OP_MSET) ? KIND_SET :
                        (op == OP_MCLR) ? KIND_CLR : KIND_TEST;
          nxt_s.skip = (op == OP_MTEST) && op_cond;
        end
        default: begin
          nxt_s.skip = 1'b0;
        end
      endcase
    end else if (tick) begin
      case (s_ff.st)
        ST_TBL: begin
          nxt_s.tword = rom_data[7:0];
          nxt_s.tvld = 1'b1;
          if (s_ff.flag) begin
            nxt_s.carry = rom_data[TOP_BIT];
          end
          stk_if.pop = 1'b1;
          nxt_s.ip = stk_if.top;
          nxt_s.st = ST_RUN;
        end
        ST_RET: begin
          nxt_s.st = ST_RUN;
        end
        default: begin
          nxt_s.st = ST_RUN;
        end
      endcase
    end
    // apb slave, zero wait states
    nxt_s.rdy = 1'b0;
    nxt_s.err = 1'b0;
    if (psel && !penable) begin
      nxt_s.rdy = 1'b1;
      nxt_s.err = !hit;
      nxt_s.rdata = '0;
      case (paddr)
        OFF_CTRL: begin
          nxt_s.rdata[CTRL_HALT] = s_ff.halt;
        end
        OFF_STAT: begin
          nxt_s.rdata[STAT_FLAG] = s_ff.flag;
          nxt_s.rdata[STAT_CARRY] = s_ff.carry;
          nxt_s.rdata[STAT_LVL +: LVL_W] = stk_if.level;
          nxt_s.rdata[STAT_ST +: 2] = s_ff.st;
          nxt_s.rdata[STAT_SKIP] = s_ff.skip;
        end
        OFF_IP: begin
          nxt_s.rdata[IP_W-1:0] = s_ff.ip;
        end
        OFF_DPTR: begin
          nxt_s.rdata[DIGIT_W-1:0] = s_ff.digit;
          nxt_s.rdata[DPTR_FILE +: FILE_W] = s_ff.file;
        end
        default: begin
          nxt_s.rdata = '0;
        end
      endcase
    end
    if (wr && paddr == OFF_CTRL) begin
      nxt_s.halt = pwdata[CTRL_HALT];
    end
    if (wr && paddr == OFF_DPTR) begin
      nxt_s.digit = pwdata[DIGIT_W-1:0];
      nxt_s.file = pwdata[DPTR_FILE +: FILE_W];
    end
    nxt_s.ready = (nxt_s.st == ST_RUN) && !nxt_s.halt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{st: ST_RUN, ready: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // outputs
  assign op_ready = s_ff.ready;
  assign machine_tick = s_ff.tick;
  assign instruction_pointer = s_ff.ip;
  assign tbl_addr = s_ff.taddr;
  assign tbl_rd = s_ff.trd;
  assign tbl_word = s_ff.tword;
  assign tbl_vld = s_ff.tvld;
  assign carry_flag = s_ff.carry;
  assign top_bit_enable_flag = s_ff.flag;
  assign ram_file = s_ff.file;
  assign ram_digit = s_ff.digit;
  assign ram_bit_sel = s_ff.bsel;
  assign ram_bit_kind = s_ff.bkind;
  assign ram_bit_stb = s_ff.bstb;
  assign port_bit_kind = s_ff.pkind;
  assign port_bit_stb = s_ff.pstb;
  assign prdata = s_ff.rdata;
  assign pready = s_ff.rdy;
  assign pslverr = s_ff.err;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_flag_never_clr: assert property (s_ff.flag && !init |=> s_ff.flag)
    else $error("top bit flag cleared without init");
  a_flag_set_op: assert property (take && !s_ff.skip && op == OP_TOPBIT |=> s_ff.flag)
    else $error("flag not set by its op");
  a_init_values: assert property (s_ff.sync2 |=> !s_ff.flag && stk_if.level == LVL_RST)
    else $error("init did not clear flag and level");
  a_carry_kept: assert property (tick && s_ff.st == ST_TBL && !s_ff.flag && !carry_wr
    |=> s_ff.carry == $past(s_ff.carry))
    else $error("carry changed with flag clear");
  a_carry_loaded: assert property (tick && s_ff.st == ST_TBL && s_ff.flag && !init
    |=> s_ff.carry == $past(rom_data[TOP_BIT]))
    else $error("carry not loaded from top bit");
  a_skip_in_place: assert property (take && s_ff.skip
    |=> s_ff.ip == $past(ip_next) && s_ff.st == ST_RUN && !s_ff.skip)
    else $error("skipped op not cancelled in place");
  a_table_two_cycles: assert property (take && !s_ff.skip && op == OP_TABLE
    |=> s_ff.trd ##0 (s_ff.st == ST_TBL) [*4] ##1 s_ff.st == ST_RUN && s_ff.tvld)
    else $error("table fetch length wrong");
  a_page_wrap: assert property (take && !s_ff.skip && op == OP_SEQ && op_len == 2'h1
    && s_ff.ip[PG_OFF_W-1:0] == 7'h7f |=> s_ff.ip[PG_OFF_W-1:0] == 7'h00
    && s_ff.ip[IP_W-1:PG_OFF_W] == $past(s_ff.ip[IP_W-1:PG_OFF_W]) + 1'b1)
    else $error("offset did not wrap to next page");
  a_page2_call: assert property (take && !s_ff.skip && op == OP_P2CALL
    |=> s_ff.ip[IP_W-1:PG_OFF_W] == PG_W'(PAGE_SUB))
    else $error("page two call landed elsewhere");
  a_table_return: assert property (take && !s_ff.skip && op == OP_TABLE
    |-> ##4 (tick ##1 s_ff.ip == $past(ip_next, 5)))
    else $error("table fetch did not resume");
  c_table_flag: cover property (tick && s_ff.st == ST_TBL && s_ff.flag);
  c_skip_ret: cover property (take && s_ff.skip && op == OP_RET);
  c_call_wrap: cover property (take && op == OP_CALL && stk_if.level == 2'h3);
endmodule : psq_seq
`default_nettype wire

/* File: sim/psq_mem_model.sv */
// partner model: program rom, data ram and output port latch
`timescale 1ns/1ps
`default_nettype none
module psq_mem_model
  import psq_pkg::*;
(
  input wire logic pclk,
  input wire logic machine_tick,
  input wire logic [10:0] tbl_addr,
  input wire logic tbl_rd,
  output logic [WORD_W-1:0] rom_data,
  input wire logic [1:0] ram_file,
  input wire logic [DIGIT_W-1:0] ram_digit,
  input wire logic [1:0] ram_bit_sel,
  input wire logic [1:0] ram_bit_kind,
  input wire logic ram_bit_stb,
  input wire logic [1:0] port_bit_kind,
  input wire logic port_bit_stb
);
  logic [WORD_W-1:0] rom [2048];
  logic [3:0] ram [64];
  logic [15:0] port;
  logic held;
  initial begin
    rom_data = '0;
    held = 1'b0;
    port = '0;
    foreach (rom[i]) rom[i] = WORD_W'(i * 37 + (i >> 4));
    foreach (ram[i]) ram[i] = '0;
  end
  // word held until taken, then churns
  always @(posedge pclk) begin
    if (tbl_rd) begin
      rom_data <= rom[tbl_addr];
      held <= 1'b1;
    end else if (machine_tick && held) begin
      held <= 1'b0;
    end else if (!held) begin
      rom_data <= ~rom_data;
    end
  end
  always @(posedge pclk) begin
    if (ram_bit_stb && ram_bit_kind != KIND_TEST) begin
      ram[{ram_file, ram_digit}][ram_bit_sel] <= (ram_bit_kind == KIND_SET);
    end
    if (port_bit_stb && port_bit_kind != KIND_TEST) begin
      port[ram_digit] <= (port_bit_kind == KIND_SET);
    end
  end
endmodule : psq_mem_model
`default_nettype wire

/* File: sim/tb_program_sequencer_stack.sv */
// testbench: sequencer checked against a reference model of pointer, stack and flags
`timescale 1ns/1ps
`default_nettype none
module tb_program_sequencer_stack;
  import psq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic wake_pin = 1'b0;
  logic op_valid = 1'b0;
  logic [3:0] op_code = '0;
  logic [1:0] op_len = '0;
  logic [10:0] op_target = '0;
  logic op_cond = 1'b0;
  logic [3:0] acc = '0;
  logic [2:0] tbl_dreg = '0;
  logic carry_wr = 1'b0;
  logic carry_wd = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic op_ready, machine_tick, tbl_rd, tbl_vld, carry_flag, top_bit_enable_flag;
  logic ram_bit_stb, port_bit_stb, pready, pslverr;
  logic [10:0] instruction_pointer, tbl_addr, m_ip, nx;
  logic [8:0] rom_data;
  logic [7:0] tbl_word;
  logic [1:0] ram_file, ram_bit_sel, ram_bit_kind, port_bit_kind, lvl;
  logic [3:0] ram_digit, sv;
  logic [31:0] prdata;
  logic [10:0] stk [4];
  logic m_f, m_c, skp;
  logic [5:0] m_dp;
  logic [3:0] m_ram [64];
  logic [15:0] m_pt;
  logic [38:0] nq [$];
  logic [7:0] wq [$];
  logic [32:0] aq [$];
  time t_take, t0;
  int mismatches = 0;
  int compares = 0;
  psq_seq i_psq_seq (.*);
  psq_mem_model i_psq_mem_model (.*);
  wire logic [38:0] st_got = {instruction_pointer, carry_flag, top_bit_enable_flag, ram_file,
    ram_digit, i_psq_mem_model.ram[{ram_file, ram_digit}], i_psq_mem_model.port};
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [38:0] g, input logic [38:0] e, input string s);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] stat();
    return {25'h0, skp, 2'h0, lvl, m_c, m_f};
  endfunction : stat
  task automatic init_model(input logic full);
    if (full) begin
      m_ip = '0;
      m_c = 1'b0;
      m_dp = '0;
      m_pt = '0;
      foreach (m_ram[i]) m_ram[i] = '0;
    end
    lvl = LVL_RST;
    m_f = 1'b0;
    skp = 1'b0;
    sv = '0;
  endtask : init_model
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    aq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0, {1'b0, e});
  endtask : rd
  task automatic settle();
    wait (nq.size() == 0);
    repeat (6) @(posedge pclk);
  endtask : settle
  task automatic setc(input logic v);
    settle();
    carry_wr <= 1'b1;
    carry_wd <= v;
    do @(posedge pclk); while (!machine_tick);
    carry_wr <= 1'b0;
    m_c = v;
  endtask : setc
  task automatic op(input psq_op_e c, input logic [1:0] l, input logic [10:0] t,
                    input logic cnd);
    logic [3:0] a;
    logic [2:0] dr;
    logic [8:0] w;
    a = 4'($urandom);
    dr = 3'($urandom);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_len <= l;
    op_target <= t;
    op_cond <= cnd;
    acc <= a;
    tbl_dreg <= dr;
    do @(posedge pclk); while (!(machine_tick && op_ready));
    op_valid <= 1'b0;
    t_take = $time;
    nx = m_ip + 11'(l);
    m_ip = nx;
    if (skp) begin
      skp = 1'b0;
    end else begin
      case (c)
        OP_JUMP: m_ip = t;
        OP_CALL, OP_P2CALL, OP_TABLE: begin
          lvl++;
          stk[lvl] = nx;
          sv[lvl] = 1'b1;
          m_ip = (c == OP_CALL) ? t : {4'h2, t[6:0]};
          if (c == OP_TABLE) begin
            w = i_psq_mem_model.rom[{t[10:7], dr, a}];
            wq.push_back(w[7:0]);
            if (m_f) m_c = w[8];
            m_ip = stk[lvl];
            lvl--;
          end
        end
        OP_RET, OP_RETS: begin
          m_ip = stk[lvl];
          lvl--;
          skp = (c == OP_RETS);
        end
        OP_TOPBIT: m_f = 1'b1;
        OP_SETX: m_dp[5:4] = t[1:0];
        OP_SETY: m_dp[3:0] = t[3:0];
        OP_PSET: m_pt[m_dp[3:0]] = 1'b1;
        OP_PCLR: m_pt[m_dp[3:0]] = 1'b0;
        OP_MSET: m_ram[m_dp][t[1:0]] = 1'b1;
        OP_MCLR: m_ram[m_dp][t[1:0]] = 1'b0;
        default: skp = cnd;
      endcase
    end
    nq.push_back({m_ip, m_c, m_f, m_dp, m_ram[m_dp], m_pt});
  endtask : op
  // ==========================================================
  // result monitor
  always @(negedge pclk) begin
    if (machine_tick && op_ready && nq.size() > 0) begin
      chk(st_got, nq.pop_front(), "state");
    end
    if (tbl_vld) begin
      chk(39'(tbl_word), 39'(wq.pop_front()), "table word");
    end
    if (psel && penable && pready) begin
      chk(39'({pslverr, pwrite ? 32'h0 : prdata}), 39'(aq.pop_front()), "apb");
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h22be));
    init_model(1'b1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STAT, stat());
    rd(OFF_IP, 32'h0);
    apb(1'b0, 8'h10, '0, {1'b1, 32'h0});
    apb(1'b1, OFF_DPTR, 32'h25, {1'b0, 32'h0});
    m_dp = 6'h25;
    rd(OFF_DPTR, 32'h25);
    for (int i = 0; i < 5; i++) begin
      op(OP_CALL, 2'd1, 11'(i * 300 + 7), 1'b0);
      settle();
      rd(OFF_STAT, stat());
    end
    op(OP_TABLE, 2'd1, 11'h5a3, 1'b0);
    repeat (4) op(OP_RET, 2'd1, '0, 1'b0);
    settle();
    rd(OFF_STAT, stat());
    op(OP_JUMP, 2'd1, 11'h07f, 1'b0);
    op(OP_SEQ, 2'd1, '0, 1'b0);
    op(OP_JUMP, 2'd1, 11'h17e, 1'b0);
    op(OP_SEQ, 2'd2, '0, 1'b0);
    op(OP_P2CALL, 2'd1, 11'h4b5, 1'b0);
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 4; v++) begin
        setc(v[0]);
        op(OP_TABLE, 2'd1, 11'($urandom), 1'b0);
      end
      op(OP_TOPBIT, 2'd1, '0, 1'b0);
    end
    settle();
    rd(OFF_STAT, stat());
    apb(1'b1, OFF_CTRL, 32'h2, {1'b0, 32'h0});
    rd(OFF_CTRL, 32'h2);
    chk(39'(op_ready), 39'd0, "halted");
    apb(1'b1, OFF_CTRL, 32'h1, {1'b0, 32'h0});
    init_model(1'b0);
    rd(OFF_STAT, stat());
    op(OP_TOPBIT, 2'd1, '0, 1'b0);
    settle();
    wake_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    wake_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    init_model(1'b0);
    rd(OFF_STAT, stat());
    for (int k = 0; k < 4; k++) begin
      op(OP_SEQ, 2'd1, '0, 1'b1);
      t0 = t_take;
      op(k == 0 ? OP_TABLE : k == 1 ? OP_RET : k == 2 ? OP_RETS : OP_CALL,
         2'd2, '0, 1'b0);
      op(OP_SEQ, 2'd1, '0, 1'b0);
      chk(39'(t_take - t0), 39'd200, "skip timing");
    end
    for (int i = 0; i < 300; i++) begin
      nx = 11'($urandom_range(15));
      if ((nx == 11'(OP_RET) || nx == 11'(OP_RETS)) && !sv[lvl]) nx = 11'(OP_CALL);
      op(psq_op_e'(nx[3:0]), 2'($urandom_range(2, 1)), 11'($urandom), 1'($urandom));
      if (i % 32 == 31) begin
        setc(1'($urandom));
        rd(OFF_STAT, stat());
      end
    end
    settle();
    end_of_test();
  end
  initial begin
    #500000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_program_sequencer_stack
`default_nettype wire
